/* logic/gtm_pkg.sv */
// constants, register map and types of the gated timer
package gtm_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] ADDR_TIMER_CTRL = 4'h0;
  localparam logic [3:0] ADDR_GATE_CTRL  = 4'h1;
  localparam logic [3:0] ADDR_COUNT_LOW  = 4'h2;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
  localparam logic [3:0] ADDR_FLAGS      = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CTRL   = 4'h6;

  // timer_control_register fields
  localparam int TC_TIMER_ON   = 0;
  localparam int TC_SYNC_BYP   = 2;
  localparam int TC_OSC_EN     = 3;
  localparam int TC_CS_LO      = 6;
  localparam int TC_CS_HI      = 7;

  // gate_control_register fields
  localparam int GC_SRC_SEL    = 0;
  localparam int GC_LEVEL      = 2;
  localparam int GC_ARM        = 3;
  localparam int GC_SPM        = 4;
  localparam int GC_TOGGLE     = 5;
  localparam int GC_POLARITY   = 6;
  localparam int GC_ENABLE     = 7;

  // flag, enable and interrupt control fields
  localparam int FL_OVERFLOW   = 0;
  localparam int FL_GATE_EVENT = 1;
  localparam int IE_OVERFLOW   = 0;
  localparam int IE_GATE_EVENT = 1;
  localparam int IC_PERIPHERAL = 0;
  localparam int IC_GLOBAL     = 1;

  // values
  localparam logic [1:0]  CS_EXTERNAL = 2'h2;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [7:0]  COMP_MAX    = 8'hFF;
  localparam logic [7:0]  COMP_ZERO   = 8'h00;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  // single-pulse acquisition states
  typedef enum logic [2:0]
  {
    SP_IDLE = 3'h1,
    SP_WAIT = 3'h2,
    SP_RUN  = 3'h4
  } gtm_sp_e;

endpackage : gtm_pkg

/* logic/gtm_gate_timer.sv */
// 16-bit timer with gate control, gate event and overflow flags
// Operation
// - companion timer wrap from FFh to 00h makes a one-cycle gate pulse
// - external gate pin is a selectable gate source
// - toggle mode flips a flop on each incrementing gate edge
// - toggle flop is cleared and held while toggle mode is off
// - after arming, counting is enabled from the next incrementing edge
// - arm flag clears by itself on the trailing edge of the pulse
// - once disarmed, further gate events never enable counting
// - toggle plus single pulse counts exactly one full gate period
// - gate level status is readable, also while gating is off
// - gate event flag sets on each falling edge of gate level status
// - gate event interrupt is flag and its enable
// - gate event flag works while gating is off
// - counter wraps FFFFh to 0000h and sets the overflow flag
// - overflow interrupt needs timer on and three enables
// - in sleep only the unsynchronised external clock counts
// - overflow in sleep wakes; global enable then gives the interrupt
// - secondary oscillator enable ignores sleep and sync bypass
// - source select zero picks the pin, one the companion pulse
// - polarity zero counts on low gate, one on high gate
// - off, free running or gated counting from timer_on and gate_enable
`timescale 1ns/1ps

module gtm_gate_timer
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_gate_pin,
  input  wire logic [7:0] comp_count,
  input  wire logic       count_tick,
  input  wire logic       sleep_mode,
  output logic            gate_level_status,
  output logic            gate_event_irq,
  output logic            overflow_irq,
  output logic            wake_req,
  output logic            sec_osc_enable
);

  typedef struct packed
  {
    logic [1:0]      cs;
    logic            sync_bypass;
    logic            osc_en;
    logic            timer_on;
    logic            gate_enable;
    logic            polarity;
    logic            toggle_en;
    logic            spm;
    logic            arm;
    logic            src_sel;
    logic            ovf_ie;
    logic            gate_ie;
    logic            peripheral_irq_enable;
    logic            global_irq_enable;
    logic            ovf_flag;
    logic            gate_flag;
    logic [15:0]     count;
    logic [7:0]      comp_prev;
    logic            t0_pulse;
    logic            gated_prev;
    logic            tog;
    logic            tsig_prev;
    logic            gls;
    logic            gls_prev;
    gtm_pkg::gtm_sp_e sp;
    logic [7:0]      rdata;
  } gtm_state_s;

  gtm_state_s st_q;
  gtm_state_s st_d;

  logic       gate_src;
  logic       gated;
  logic       tsig;
  logic       tsig_rise;
  logic       gls_fall;
  logic       gate_active;
  logic       sleep_ok;
  logic       inc;
  logic       wr_tc;
  logic       wr_gc;
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_fl;
  logic [7:0] rd_mux;

  always_comb
  begin
    wr_tc = reg_wr && (reg_addr == gtm_pkg::ADDR_TIMER_CTRL);
    wr_gc = reg_wr && (reg_addr == gtm_pkg::ADDR_GATE_CTRL);
    wr_lo = reg_wr && (reg_addr == gtm_pkg::ADDR_COUNT_LOW);
    wr_hi = reg_wr && (reg_addr == gtm_pkg::ADDR_COUNT_HIGH);
    wr_fl = reg_wr && (reg_addr == gtm_pkg::ADDR_FLAGS);

    // gate source and polarity
    gate_src = st_q.src_sel ? st_q.t0_pulse : ext_gate_pin;
    gated    = st_q.polarity ? gate_src : !gate_src;
    tsig      = st_q.toggle_en ? st_q.tog : gated;
    tsig_rise = tsig && !st_q.tsig_prev;
    gls_fall  = st_q.gls_prev && !st_q.gls;

    // count enable
    gate_active = st_q.gate_enable ? st_q.gls : 1'b1;
    sleep_ok = !sleep_mode ||
               (st_q.sync_bypass && (st_q.cs == gtm_pkg::CS_EXTERNAL));
    inc = st_q.timer_on && gate_active && count_tick && sleep_ok;

    rd_mux = gtm_pkg::BYTE_ZERO;
    unique case (reg_addr)
      gtm_pkg::ADDR_TIMER_CTRL:
      begin
        rd_mux[gtm_pkg::TC_CS_HI:gtm_pkg::TC_CS_LO] = st_q.cs;
        rd_mux[gtm_pkg::TC_SYNC_BYP] = st_q.sync_bypass;
        rd_mux[gtm_pkg::TC_OSC_EN]   = st_q.osc_en;
        rd_mux[gtm_pkg::TC_TIMER_ON] = st_q.timer_on;
      end
      gtm_pkg::ADDR_GATE_CTRL:
      begin
        rd_mux[gtm_pkg::GC_ENABLE]   = st_q.gate_enable;
        rd_mux[gtm_pkg::GC_POLARITY] = st_q.polarity;
        rd_mux[gtm_pkg::GC_TOGGLE]   = st_q.toggle_en;
        rd_mux[gtm_pkg::GC_SPM]      = st_q.spm;
        rd_mux[gtm_pkg::GC_ARM]      = st_q.arm;
        rd_mux[gtm_pkg::GC_LEVEL]    = st_q.gls;
        rd_mux[gtm_pkg::GC_SRC_SEL]  = st_q.src_sel;
      end
      gtm_pkg::ADDR_COUNT_LOW:  rd_mux = st_q.count[7:0];
      gtm_pkg::ADDR_COUNT_HIGH: rd_mux = st_q.count[15:8];
      gtm_pkg::ADDR_FLAGS:
      begin
        rd_mux[gtm_pkg::FL_OVERFLOW]   = st_q.ovf_flag;
        rd_mux[gtm_pkg::FL_GATE_EVENT] = st_q.gate_flag;
      end
      gtm_pkg::ADDR_IRQ_ENABLE:
      begin
        rd_mux[gtm_pkg::IE_OVERFLOW]   = st_q.ovf_ie;
        rd_mux[gtm_pkg::IE_GATE_EVENT] = st_q.gate_ie;
      end
      gtm_pkg::ADDR_IRQ_CTRL:
      begin
        rd_mux[gtm_pkg::IC_PERIPHERAL] = st_q.peripheral_irq_enable;
        rd_mux[gtm_pkg::IC_GLOBAL]     = st_q.global_irq_enable;
      end
      default: rd_mux = gtm_pkg::BYTE_ZERO;
    endcase

    st_d = st_q;
    st_d.rdata = reg_rd ? rd_mux : gtm_pkg::BYTE_ZERO;

    // control registers
    if (wr_tc)
    begin
      st_d.cs = reg_wdata[gtm_pkg::TC_CS_HI:gtm_pkg::TC_CS_LO];
      st_d.sync_bypass = reg_wdata[gtm_pkg::TC_SYNC_BYP];
      st_d.osc_en      = reg_wdata[gtm_pkg::TC_OSC_EN];
      st_d.timer_on    = reg_wdata[gtm_pkg::TC_TIMER_ON];
    end
    if (wr_gc)
    begin
      st_d.gate_enable = reg_wdata[gtm_pkg::GC_ENABLE];
      st_d.polarity    = reg_wdata[gtm_pkg::GC_POLARITY];
      st_d.toggle_en   = reg_wdata[gtm_pkg::GC_TOGGLE];
      st_d.spm         = reg_wdata[gtm_pkg::GC_SPM];
      st_d.src_sel     = reg_wdata[gtm_pkg::GC_SRC_SEL];
    end
    if (reg_wr && (reg_addr == gtm_pkg::ADDR_IRQ_ENABLE))
    begin
      st_d.ovf_ie  = reg_wdata[gtm_pkg::IE_OVERFLOW];
      st_d.gate_ie = reg_wdata[gtm_pkg::IE_GATE_EVENT];
    end
    if (reg_wr && (reg_addr == gtm_pkg::ADDR_IRQ_CTRL))
    begin
      st_d.peripheral_irq_enable = reg_wdata[gtm_pkg::IC_PERIPHERAL];
      st_d.global_irq_enable  = reg_wdata[gtm_pkg::IC_GLOBAL];
    end

    // companion wrap pulse
    st_d.comp_prev = comp_count;
    st_d.t0_pulse  = (st_q.comp_prev == gtm_pkg::COMP_MAX) &&
                     (comp_count == gtm_pkg::COMP_ZERO);

    // toggle flop
    st_d.gated_prev = gated;
    if (!st_q.toggle_en)
      st_d.tog = 1'b0;
    else if (gated && !st_q.gated_prev)
      st_d.tog = !st_q.tog;

    // single-pulse acquisition
    st_d.tsig_prev = tsig;
    unique case (st_q.sp)
      gtm_pkg::SP_IDLE:
        if (st_q.spm && st_q.arm)
          st_d.sp = gtm_pkg::SP_WAIT;
      gtm_pkg::SP_WAIT:
        if (!st_q.spm || !st_q.arm)
          st_d.sp = gtm_pkg::SP_IDLE;
        else if (tsig_rise)
          st_d.sp = gtm_pkg::SP_RUN;
      gtm_pkg::SP_RUN:
        if (!st_q.spm || !st_q.arm || !tsig)
          st_d.sp = gtm_pkg::SP_IDLE;
      default: st_d.sp = gtm_pkg::SP_IDLE;
    endcase
    if ((st_q.sp == gtm_pkg::SP_RUN) && st_q.spm && !tsig)
      st_d.arm = 1'b0;
    if (wr_gc)
      st_d.arm = reg_wdata[gtm_pkg::GC_ARM];

    // gate level status
    if (st_q.spm)
      st_d.gls = tsig && st_q.arm && ((st_q.sp == gtm_pkg::SP_RUN) ||
                 ((st_q.sp == gtm_pkg::SP_WAIT) && tsig_rise));
    else
      st_d.gls = tsig;
    st_d.gls_prev = st_q.gls;

    // counter
    if (wr_lo)
      st_d.count[7:0] = reg_wdata;
    if (wr_hi)
      st_d.count[15:8] = reg_wdata;
    if (inc && !wr_lo && !wr_hi)
      st_d.count = st_q.count + 16'h0001;

    // flags, set wins over the software write
    if (wr_fl)
    begin
      st_d.ovf_flag  = reg_wdata[gtm_pkg::FL_OVERFLOW];
      st_d.gate_flag = reg_wdata[gtm_pkg::FL_GATE_EVENT];
    end
    if (inc && !wr_lo && !wr_hi && (st_q.count == gtm_pkg::COUNT_MAX))
      st_d.ovf_flag = 1'b1;
    if (gls_fall)
      st_d.gate_flag = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      st_q       <= '0;
      st_q.sp    <= gtm_pkg::SP_IDLE;
      st_q.count <= gtm_pkg::COUNT_RST;
    end
    else
      st_q <= st_d;
  end

  assign reg_rdata         = st_q.rdata;
  assign gate_level_status = st_q.gls;
  assign gate_event_irq    = st_q.gate_flag && st_q.gate_ie;
  assign wake_req          = st_q.ovf_flag && st_q.ovf_ie &&
                             st_q.peripheral_irq_enable && st_q.timer_on;
  assign overflow_irq      = wake_req && st_q.global_irq_enable;
  assign sec_osc_enable    = st_q.osc_en;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_armed_rise;
    (st_q.sp == gtm_pkg::SP_WAIT) && st_q.spm && st_q.arm && tsig_rise
      && !wr_gc;
  endsequence

  sequence s_pulse_end;
    (st_q.sp == gtm_pkg::SP_RUN) && st_q.spm && !tsig && !wr_gc;
  endsequence

  chk_wrap_pulse: assert property (
    (st_q.comp_prev == gtm_pkg::COMP_MAX) &&
    (comp_count == gtm_pkg::COMP_ZERO) |=> st_q.t0_pulse ##1 !st_q.t0_pulse)
    else $error("companion wrap pulse wrong");

  chk_toggle_flip: assert property (
    st_q.toggle_en && gated && !st_q.gated_prev |=>
    st_q.tog != $past(st_q.tog))
    else $error("toggle flop did not flip");

  chk_toggle_held: assert property (
    !st_q.toggle_en [*2] |-> !st_q.tog)
    else $error("toggle flop not held clear");

  chk_sp_capture: assert property (
    s_armed_rise |=> (st_q.sp == gtm_pkg::SP_RUN) && st_q.gls)
    else $error("armed edge did not open gate");

  chk_sp_disarm: assert property (
    s_pulse_end |=> !st_q.arm && (st_q.sp == gtm_pkg::SP_IDLE))
    else $error("arm flag not cleared at pulse end");

  chk_sp_ignore: assert property (
    st_q.spm && !st_q.arm && !wr_gc |=> !st_q.gls)
    else $error("disarmed gate opened");

  chk_sp_wait_closed: assert property (
    (st_q.sp == gtm_pkg::SP_WAIT) && st_q.spm && !tsig_rise |=> !st_q.gls)
    else $error("gate opened without armed edge");

  chk_gate_flag: assert property (
    st_q.gls_prev && !st_q.gls |=> st_q.gate_flag)
    else $error("gate event flag not set");

  chk_gate_irq: assert property (
    st_q.gls_prev && !st_q.gls && st_q.gate_ie &&
    !(reg_wr && (reg_addr == gtm_pkg::ADDR_IRQ_ENABLE)) |=> gate_event_irq)
    else $error("gate event interrupt wrong");

  chk_count_wrap: assert property (
    inc && !wr_lo && !wr_hi && (st_q.count == gtm_pkg::COUNT_MAX) |=>
    (st_q.count == gtm_pkg::COUNT_RST) && st_q.ovf_flag)
    else $error("rollover or overflow flag wrong");

  chk_ovf_irq: assert property (
    overflow_irq |-> st_q.ovf_flag && st_q.timer_on && st_q.ovf_ie &&
    st_q.peripheral_irq_enable && st_q.global_irq_enable)
    else $error("overflow interrupt without all enables");

  chk_timer_off: assert property (
    !st_q.timer_on && !wr_lo && !wr_hi |=> $stable(st_q.count))
    else $error("counter moved while off");

  chk_sleep_hold: assert property (
    sleep_mode && !st_q.sync_bypass && !wr_lo && !wr_hi |=>
    $stable(st_q.count))
    else $error("synchronous counter ran in sleep");

  chk_free_run: assert property (
    st_q.timer_on && !st_q.gate_enable && count_tick && !sleep_mode
    && !wr_lo && !wr_hi |=> st_q.count == $past(st_q.count) + 16'h0001)
    else $error("free running count missed");

endmodule : gtm_gate_timer

/* tb/gtm_gate_source.sv */
// companion timer, gate pin and timer clock model
`timescale 1ns/1ps

module gtm_gate_source
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       gate_lvl,
  input  wire logic       comp_run,
  input  wire logic       tick_run,
  output logic            ext_gate_pin,
  output logic      [7:0] comp_count,
  output logic            count_tick
);
  // the pin is driven from outside, so reset leaves it alone
  always_ff @(posedge core_clk)
    ext_gate_pin <= gate_lvl;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      comp_count <= 8'hF0;
      count_tick <= 1'b0;
    end
    else
    begin
      comp_count <= comp_count + {7'h00, comp_run};
      count_tick <= tick_run & !count_tick;
    end
  end
endmodule : gtm_gate_source

/* tb/gtm_gate_timer_bench.sv */
// self-checking bench of the gated timer
`timescale 1ns/1ps

module gtm_gate_timer_bench;
  logic       core_clk;
  logic       rst_b;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       ext_gate_pin;
  logic [7:0] comp_count;
  logic       count_tick;
  logic       sleep_mode;
  logic       gate_level_status;
  logic       gate_event_irq;
  logic       overflow_irq;
  logic       wake_req;
  logic       sec_osc_enable;
  logic       gate_lvl;
  logic       comp_run;
  logic       tick_run;
  logic [7:0] rv;
  logic [7:0] kept;
  int         mismatches;
  int         checks_done;

  gtm_gate_timer i_gtm_gate_timer
  (
    .core_clk          (core_clk),
    .rst_b             (rst_b),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .ext_gate_pin      (ext_gate_pin),
    .comp_count        (comp_count),
    .count_tick        (count_tick),
    .sleep_mode        (sleep_mode),
    .gate_level_status (gate_level_status),
    .gate_event_irq    (gate_event_irq),
    .overflow_irq      (overflow_irq),
    .wake_req          (wake_req),
    .sec_osc_enable    (sec_osc_enable)
  );

  gtm_gate_source i_gtm_gate_source
  (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .gate_lvl     (gate_lvl),
    .comp_run     (comp_run),
    .tick_run     (tick_run),
    .ext_gate_pin (ext_gate_pin),
    .comp_count   (comp_count),
    .count_tick   (count_tick)
  );

  always #5 core_clk = ~core_clk;

  task automatic tally_and_finish();
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [7:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic drive(input logic t, g, c, s);
    @(posedge core_clk);
    tick_run   <= t;
    gate_lvl   <= g;
    comp_run   <= c;
    sleep_mode <= s;
  endtask : drive

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  task automatic wait_gls(input logic v);
    int n;
    n = 0;
    #1;
    while (gate_level_status !== v && n < 400)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("gate level", {7'h00, v}, {7'h00, gate_level_status});
    if (n == 400)
      tally_and_finish();
  endtask : wait_gls

  task automatic sc_reset();
    wr(4'hF, 8'hFF);
    for (int a = 0; a < 16; a++)
    begin
      rd(a[3:0], rv);
      chk("reset or unmapped", 8'h00, rv);
    end
  endtask : sc_reset

  task automatic sc_overflow();
    wr(4'h0, 8'h01);
    wr(4'h3, 8'hFF);
    wr(4'h2, 8'hFE);
    drive(1, 1, 0, 0);
    idle(12);
    drive(0, 1, 0, 0);
    rd(4'h3, rv);
    chk("count high", 8'h00, rv);
    rd(4'h4, rv);
    chk("flags", 8'h01, rv);
    wr(4'h5, 8'h01);
    wr(4'h6, 8'h01);
    chk("wake", 8'h01, {7'h00, wake_req});
    chk("ovf irq", 8'h00, {7'h00, overflow_irq});
    wr(4'h6, 8'h03);
    chk("ovf irq", 8'h01, {7'h00, overflow_irq});
    wr(4'h0, 8'h00);
    chk("wake off", 8'h00, {7'h00, wake_req});
    rd(4'h2, kept);
    drive(1, 1, 0, 0);
    idle(10);
    drive(0, 1, 0, 0);
    rd(4'h2, rv);
    chk("count off", kept, rv);
    wr(4'h4, 8'h00);
    rd(4'h4, rv);
    chk("flags clear", 8'h00, rv);
    wr(4'h5, 8'h00);
  endtask : sc_overflow

  task automatic sc_gate_pin();
    wr(4'h0, 8'h01);
    wr(4'h1, 8'hC0);
    drive(1, 0, 0, 0);
    wr(4'h2, 8'h00);
    idle(4);
    wr(4'h4, 8'h00);
    idle(10);
    rd(4'h2, rv);
    chk("count held", 8'h00, rv);
    drive(1, 1, 0, 0);
    wait_gls(1);
    rd(4'h1, rv);
    chk("gate ctrl", 8'hC4, rv);
    idle(1);
    chk("rdata idle", 8'h00, reg_rdata);
    idle(10);
    rd(4'h2, rv);
    chk("counting", 8'h01, {7'h00, rv != 8'h00});
    drive(1, 0, 0, 0);
    wait_gls(0);
    idle(3);
    rd(4'h4, rv);
    chk("gate flag", 8'h02, rv);
    wr(4'h5, 8'h02);
    chk("gate irq", 8'h01, {7'h00, gate_event_irq});
    wr(4'h5, 8'h00);
    wr(4'h4, 8'h00);
  endtask : sc_gate_pin

  task automatic sc_companion();
    wr(4'h1, 8'h41);
    drive(1, 0, 1, 0);
    wait_gls(1);
    idle(1);
    #1;
    chk("pulse end", 8'h00, {7'h00, gate_level_status});
    drive(1, 0, 0, 0);
    idle(3);
    rd(4'h4, rv);
    chk("gate flag", 8'h02, rv);
    wr(4'h4, 8'h00);
  endtask : sc_companion

  task automatic sc_toggle();
    wr(4'h1, 8'hC0);
    wr(4'h1, 8'hE0);
    drive(1, 1, 0, 0);
    wait_gls(1);
    drive(1, 0, 0, 0);
    idle(4);
    chk("toggle hold", 8'h01, {7'h00, gate_level_status});
    drive(1, 1, 0, 0);
    wait_gls(0);
    drive(1, 0, 0, 0);
    drive(1, 1, 0, 0);
    wait_gls(1);
    wr(4'h1, 8'hC0);
    drive(1, 0, 0, 0);
    wr(4'h1, 8'hE0);
    idle(3);
    chk("toggle clr", 8'h00, {7'h00, gate_level_status});
    drive(1, 1, 0, 0);
    wait_gls(1);
    wr(4'h1, 8'hC0);
    drive(1, 0, 0, 0);
    wr(4'h4, 8'h00);
  endtask : sc_toggle

  task automatic sc_single();
    wr(4'h1, 8'hD0);
    wr(4'h1, 8'hD8);
    wr(4'h2, 8'h00);
    idle(6);
    rd(4'h2, rv);
    chk("not yet", 8'h00, rv);
    drive(1, 1, 0, 0);
    idle(10);
    drive(1, 0, 0, 0);
    idle(4);
    rd(4'h1, rv);
    chk("disarmed", 8'hD0, rv);
    rd(4'h2, kept);
    chk("pulse", 8'h01, {7'h00, kept != 8'h00});
    drive(1, 1, 0, 0);
    idle(10);
    drive(1, 0, 0, 0);
    idle(4);
    rd(4'h2, rv);
    chk("ignored", kept, rv);
    wr(4'h1, 8'hC0);
    wr(4'h1, 8'hF0);
    wr(4'h1, 8'hF8);
    drive(1, 1, 0, 0);
    wait_gls(1);
    drive(1, 0, 0, 0);
    idle(4);
    chk("period", 8'h01, {7'h00, gate_level_status});
    drive(1, 1, 0, 0);
    wait_gls(0);
    rd(4'h1, rv);
    chk("disarmed", 8'hF0, rv);
    wr(4'h1, 8'hC0);
  endtask : sc_single

  task automatic sc_sleep();
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h01);
    drive(1, 0, 0, 1);
    wr(4'h2, 8'h00);
    idle(10);
    rd(4'h2, rv);
    chk("sleep held", 8'h00, rv);
    wr(4'h0, 8'h05);
    idle(10);
    rd(4'h2, rv);
    chk("sleep internal", 8'h00, rv);
    wr(4'h0, 8'h8D);
    chk("osc", 8'h01, {7'h00, sec_osc_enable});
    idle(10);
    rd(4'h2, rv);
    chk("sleep count", 8'h01, {7'h00, rv != 8'h00});
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h01);
    wr(4'h3, 8'hFF);
    wr(4'h2, 8'hF0);
    idle(40);
    chk("sleep wake", 8'h01, {7'h00, wake_req});
    chk("sleep irq", 8'h01, {7'h00, overflow_irq});
    wr(4'h6, 8'h01);
    chk("wake no gie", 8'h01, {7'h00, wake_req});
    chk("irq no gie", 8'h00, {7'h00, overflow_irq});
  endtask : sc_sleep

  initial
  begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_mode = 1'b0;
    gate_lvl = 1'b1;
    comp_run = 1'b0;
    tick_run = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    sc_reset();
    sc_overflow();
    sc_gate_pin();
    sc_companion();
    sc_toggle();
    sc_single();
    sc_sleep();
    tally_and_finish();
  end
endmodule : gtm_gate_timer_bench
